// [sopc_regs.vh]
/*
 * Register offsets, field positions and reset values of the system
 * option and port A pin control bank.
 * Assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register.
 */
`ifndef SOPC_REGS_VH
`define SOPC_REGS_VH

`define SOPC_OFS_SYS_OPT      8'h00
`define SOPC_OFS_PWR_MGMT     8'h04
`define SOPC_OFS_PULLUP       8'h08
`define SOPC_OFS_SLEW         8'h0C
`define SOPC_OFS_PERIODIC     8'h10

`define SOPC_BIT_WDOG_EN      7
`define SOPC_BIT_WDOG_LONG    6
`define SOPC_BIT_STOP_PERMIT  5
`define SOPC_BIT_SPARE        4
`define SOPC_BIT_DEBUG_PIN    1
`define SOPC_BIT_RESET_PIN    0

`define SOPC_BIT_LV_FLAG      7
`define SOPC_BIT_LV_ACK       6
`define SOPC_BIT_LV_ENABLE    2
`define SOPC_BIT_LV_RESERVED  1
`define SOPC_BIT_BANDGAP      0

`define SOPC_BIT_PER_CLKSEL   3

`define SOPC_RST_SYS_OPT      8'hD2
`define SOPC_RST_PWR_MGMT     8'h1C
`define SOPC_RST_PULLUP       8'h00
`define SOPC_RST_SLEW         8'h3F
`define SOPC_PORT_MASK        8'h3F

`define SOPC_RESP_OKAY        2'h0
`define SOPC_RESP_SLVERR      2'h2

`define SOPC_SLOW_CLK_NS      1000000
`define SOPC_CLK_NS           5

`endif

// [sopc_period_sel.v]
/*
 * Decodes the 3-bit periodic interrupt select into a period length
 * counted in periods of the selected slow clock source.
 * Assumes the slow source runs at 1 kHz or at the 32 kHz generator rate.
 */
`timescale 1ns/1ps
`default_nettype none

module sopc_period_sel (
  // Selection
  input  wire [2:0]  select_in,
  input  wire        ext_source_in,
  // Decoded period
  output reg  [15:0] period_out,
  output wire        enable_out
);

  assign enable_out = (select_in != 3'h0);

  always @* begin
    period_out = 16'h0000;
    if (ext_source_in) begin
      case (select_in)
        3'h1:    period_out = 16'h0100;
        3'h2:    period_out = 16'h0400;
        3'h3:    period_out = 16'h0800;
        3'h4:    period_out = 16'h1000;
        3'h5:    period_out = 16'h2000;
        3'h6:    period_out = 16'h4000;
        3'h7:    period_out = 16'h8000;
        default: period_out = 16'h0000;
      endcase
    end else begin
      case (select_in)
        3'h1:    period_out = 16'h0008;
        3'h2:    period_out = 16'h0020;
        3'h3:    period_out = 16'h0040;
        3'h4:    period_out = 16'h0080;
        3'h5:    period_out = 16'h0100;
        3'h6:    period_out = 16'h0200;
        3'h7:    period_out = 16'h0400;
        default: period_out = 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// [sopc_bank.v]
/*
 * System option, power management and port A pin control register bank
 * with an AXI4-Lite slave.
 * Assumes one clock; rst_in is any reset, por_in marks a power-on reset
 * and is held together with rst_in.
 */
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sopc_regs.vh"

module sopc_bank #(
  parameter integer SLOW_DIV = `SOPC_SLOW_CLK_NS / `SOPC_CLK_NS
) (
  // Clock and resets
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        por_in,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // System events and pin state
  input  wire        low_voltage_event_in,
  input  wire        stop_exec_in,
  input  wire        ext_clk_tick_in,
  input  wire [5:0]  pin_output_in,
  input  wire [5:0]  pin_analog_in,
  // Controls to the rest of the device
  output wire        watchdog_enable_out,
  output wire        watchdog_long_timeout_out,
  output wire        stop_enter_out,
  output wire        illegal_stop_reset_out,
  output wire        debug_pin_function_out,
  output wire        reset_pin_enable_out,
  output wire        reset_pin_pullup_out,
  output wire        low_voltage_detect_enable_out,
  output wire        bandgap_enable_out,
  output wire        periodic_tick_out,
  output wire [5:0]  pin_pullup_out,
  output wire [5:0]  pin_slew_out
);

  // Register state
  reg  [7:0]  system_options_one;
  reg         sys_opt_locked;
  reg  [7:0]  power_mgmt_ctrl;
  reg         lv_enable_locked;
  reg         low_voltage_flag;
  reg  [7:0]  port_a_pullup_enable;
  reg  [7:0]  port_a_slew_enable;
  reg  [3:0]  periodic_ctrl;

  // Write channel capture
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;

  // Periodic interrupt timing
  reg  [31:0] slow_div_cnt;
  reg  [15:0] period_cnt;
  reg         periodic_tick;
  wire [15:0] period_len;
  wire        period_on;
  wire        slow_tick;

  wire        wr_go;
  wire        wr_lane0;
  wire        wr_known;
  wire        rd_go;
  wire        lv_ack;
  reg  [7:0]  rd_byte;
  reg         rd_known;

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  assign wr_go    = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_lane0 = wr_go && w_strb[0];
  assign wr_known = (aw_addr[7:2] <= `SOPC_OFS_PERIODIC >> 2);
  assign rd_go    = s_axi_arvalid_in && s_axi_arready_out;

  // Address and data may arrive in either order
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= s_axi_awaddr_in;
        aw_held <= 1'b1;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        w_held <= 1'b1;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `SOPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_known ? `SOPC_RESP_OKAY : `SOPC_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // System options: write once, bit 0 kept across non-power-on resets
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      system_options_one <= `SOPC_RST_SYS_OPT;
      sys_opt_locked     <= 1'b0;
    end else if (wr_lane0 && aw_addr == `SOPC_OFS_SYS_OPT && !sys_opt_locked) begin
      system_options_one <= w_data[7:0] & 8'hF3;
      sys_opt_locked     <= 1'b1;
    end
  end

  // Reset pin enable survives every reset but power-on
  reg reset_pin_enable;
  always @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      reset_pin_enable <= 1'b0;
    end else if (rst_in) begin
      reset_pin_enable <= reset_pin_enable;
    end else if (wr_lane0 && aw_addr == `SOPC_OFS_SYS_OPT && !sys_opt_locked) begin
      reset_pin_enable <= w_data[`SOPC_BIT_RESET_PIN];
    end
  end

  assign lv_ack = wr_lane0 && aw_addr == `SOPC_OFS_PWR_MGMT && w_data[`SOPC_BIT_LV_ACK];

  // Power management control; detect enable is write once
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_mgmt_ctrl  <= `SOPC_RST_PWR_MGMT;
      lv_enable_locked <= 1'b0;
    end else if (wr_lane0 && aw_addr == `SOPC_OFS_PWR_MGMT) begin
      power_mgmt_ctrl[5:3] <= w_data[5:3];
      power_mgmt_ctrl[`SOPC_BIT_BANDGAP] <= w_data[`SOPC_BIT_BANDGAP];
      power_mgmt_ctrl[`SOPC_BIT_LV_RESERVED] <= 1'b0;
      if (!lv_enable_locked) begin
        power_mgmt_ctrl[`SOPC_BIT_LV_ENABLE] <= w_data[`SOPC_BIT_LV_ENABLE];
        lv_enable_locked <= 1'b1;
      end
    end
  end

  // Event beats acknowledge in the same cycle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_voltage_flag <= 1'b0;
    end else if (low_voltage_event_in && power_mgmt_ctrl[`SOPC_BIT_LV_ENABLE]) begin
      low_voltage_flag <= 1'b1;
    end else if (lv_ack) begin
      low_voltage_flag <= 1'b0;
    end
  end

  // Pin control and periodic interrupt select registers
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_a_pullup_enable <= `SOPC_RST_PULLUP;
      port_a_slew_enable   <= `SOPC_RST_SLEW;
      periodic_ctrl        <= 4'h0;
    end else if (wr_lane0) begin
      if (aw_addr == `SOPC_OFS_PULLUP)
        port_a_pullup_enable <= w_data[7:0] & `SOPC_PORT_MASK;
      if (aw_addr == `SOPC_OFS_SLEW)
        port_a_slew_enable <= w_data[7:0] & `SOPC_PORT_MASK;
      if (aw_addr == `SOPC_OFS_PERIODIC)
        periodic_ctrl <= w_data[3:0];
    end
  end

  // Read path
  always @* begin
    rd_byte  = 8'h00;
    rd_known = 1'b1;
    case (s_axi_araddr_in)
      `SOPC_OFS_SYS_OPT: begin
        rd_byte = system_options_one;
        rd_byte[`SOPC_BIT_RESET_PIN] = reset_pin_enable;
      end
      `SOPC_OFS_PWR_MGMT: begin
        rd_byte = power_mgmt_ctrl;
        rd_byte[`SOPC_BIT_LV_FLAG] = low_voltage_flag;
        rd_byte[`SOPC_BIT_LV_ACK]  = 1'b0;
      end
      `SOPC_OFS_PULLUP:   rd_byte = port_a_pullup_enable;
      `SOPC_OFS_SLEW:     rd_byte = port_a_slew_enable;
      `SOPC_OFS_PERIODIC: rd_byte = {4'h0, periodic_ctrl};
      default:            rd_known = 1'b0;
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `SOPC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {24'h00_0000, rd_byte};
      s_axi_rresp_out  <= rd_known ? `SOPC_RESP_OKAY : `SOPC_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Periodic interrupt timer
  sopc_period_sel u_period_sel (
    .select_in     (periodic_ctrl[2:0]),
    .ext_source_in (periodic_ctrl[`SOPC_BIT_PER_CLKSEL]),
    .period_out    (period_len),
    .enable_out    (period_on)
  );

  // Free-running 1 kHz prescaler is not restarted on selection
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slow_div_cnt <= 32'h0000_0000;
    end else if (slow_div_cnt == SLOW_DIV - 1) begin
      slow_div_cnt <= 32'h0000_0000;
    end else begin
      slow_div_cnt <= slow_div_cnt + 32'h0000_0001;
    end
  end

  assign slow_tick = periodic_ctrl[`SOPC_BIT_PER_CLKSEL] ? ext_clk_tick_in
                                                         : (slow_div_cnt == SLOW_DIV - 1);

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      period_cnt    <= 16'h0000;
      periodic_tick <= 1'b0;
    end else if (!period_on) begin
      period_cnt    <= 16'h0000;
      periodic_tick <= 1'b0;
    end else if (slow_tick) begin
      periodic_tick <= (period_cnt == period_len - 16'h0001);
      period_cnt    <= (period_cnt == period_len - 16'h0001) ? 16'h0000
                                                             : period_cnt + 16'h0001;
    end else begin
      periodic_tick <= 1'b0;
    end
  end

  // Control outputs
  assign watchdog_enable_out       = system_options_one[`SOPC_BIT_WDOG_EN];
  assign watchdog_long_timeout_out = system_options_one[`SOPC_BIT_WDOG_LONG];
  assign stop_enter_out         = stop_exec_in && system_options_one[`SOPC_BIT_STOP_PERMIT];
  assign illegal_stop_reset_out = stop_exec_in && !system_options_one[`SOPC_BIT_STOP_PERMIT];
  assign debug_pin_function_out = system_options_one[`SOPC_BIT_DEBUG_PIN];
  assign reset_pin_enable_out   = reset_pin_enable;
  assign reset_pin_pullup_out   = reset_pin_enable;
  assign low_voltage_detect_enable_out = power_mgmt_ctrl[`SOPC_BIT_LV_ENABLE];
  assign bandgap_enable_out     = power_mgmt_ctrl[`SOPC_BIT_BANDGAP];
  assign periodic_tick_out      = periodic_tick;

  // Pullup off for outputs, analog use, and output-only pin 4
  assign pin_pullup_out = port_a_pullup_enable[5:0] & ~pin_output_in & ~pin_analog_in
                          & 6'h2F;
  // Slew only on driven outputs, never on input-only pin 5
  assign pin_slew_out   = port_a_slew_enable[5:0] & pin_output_in & 6'h1F;

endmodule

`default_nettype wire

// [sopc_bank_checker.sv]
/* Port assertions for the option and pin control bank.
   Bound to every sopc_bank; one clock, rst_in asynchronous active high. */
`timescale 1ns/1ps
`default_nettype none
module sopc_bank_checker #(
  parameter integer SLOW_DIV = 4
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Bus answers
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  // Controls and pins
  input wire logic        stop_exec_in,
  input wire logic        stop_enter_out,
  input wire logic        illegal_stop_reset_out,
  input wire logic        debug_pin_function_out,
  input wire logic [5:0]  pin_output_in,
  input wire logic [5:0]  pin_analog_in,
  input wire logic [5:0]  pin_pullup_out,
  input wire logic [5:0]  pin_slew_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence rd_answer;
    s_axi_rvalid_out && (s_axi_rdata_out[31:8] == 24'h000000);
  endsequence
  chk_pullup_forced: assert property (
    (pin_pullup_out & (pin_output_in | pin_analog_in)) == 6'h00)
    else $error("pullup on at driven or analog pin");
  chk_pullup_pin4: assert property (!pin_pullup_out[4])
    else $error("pullup on at output-only pin");
  chk_slew_inputs: assert property ((pin_slew_out & ~pin_output_in) == 6'h00)
    else $error("slew limit on input pin");
  chk_slew_pin5: assert property (!pin_slew_out[5])
    else $error("slew limit on input-only pin");
  chk_stop_split: assert property (
    stop_exec_in |-> stop_enter_out != illegal_stop_reset_out)
    else $error("stop neither entered nor refused");
  chk_debug_reset: assert property ($fell(rst_in) |-> debug_pin_function_out)
    else $error("debug pin function not set after reset");
  chk_bvalid_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  chk_read_answer: assert property (rd_taken |=> rd_answer)
    else $error("read answer late or upper bits set");
endmodule
bind sopc_bank sopc_bank_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .stop_exec_in(stop_exec_in),
  .stop_enter_out(stop_enter_out), .illegal_stop_reset_out(illegal_stop_reset_out),
  .debug_pin_function_out(debug_pin_function_out), .pin_output_in(pin_output_in),
  .pin_analog_in(pin_analog_in), .pin_pullup_out(pin_pullup_out),
  .pin_slew_out(pin_slew_out));
`default_nettype wire

// [tb_sopc_bank.sv]
/* Self-checking bench for sopc_bank over AXI4-Lite.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_sopc_bank;
  localparam integer DIV = 4;
  reg         clk_in = 1'b0, rst_in = 1'b1, por_in = 1'b1;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, d, v, p, s;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg         lv_ev = 1'b0, stop_ex = 1'b0, ext_tick = 1'b0;
  reg  [1:0]  ecnt = 2'h0;
  reg  [5:0]  pin_o = 6'h00, pin_a = 6'h00;
  wire        awready, wready, bvalid, arready, rvalid, tick;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        wd_en, wd_long, st_en, st_ill, dbg, rpe, rpu, low_voltage_detect_enable, bg;
  wire [5:0]  pu, sl;
  integer     num_errors = 0, compares = 0, seed = 32'h6aeac9f6, i, n;

  sopc_bank #(.SLOW_DIV(DIV)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .low_voltage_event_in(lv_ev), .stop_exec_in(stop_ex),
    .ext_clk_tick_in(ext_tick), .pin_output_in(pin_o), .pin_analog_in(pin_a),
    .watchdog_enable_out(wd_en), .watchdog_long_timeout_out(wd_long),
    .stop_enter_out(st_en), .illegal_stop_reset_out(st_ill), .debug_pin_function_out(dbg),
    .reset_pin_enable_out(rpe), .reset_pin_pullup_out(rpu),
    .low_voltage_detect_enable_out(low_voltage_detect_enable), .bandgap_enable_out(bg), .periodic_tick_out(tick),
    .pin_pullup_out(pu), .pin_slew_out(sl));

  always #2.5 clk_in = ~clk_in;
  // Slow source tick every 4 clocks
  always @(posedge clk_in) begin
    ecnt <= ecnt + 2'h1;
    ext_tick <= (ecnt == 2'h3);
  end

  function integer per_len(input integer c, input integer x);
    per_len = ((x != 0) ? 256 : 8) * ((c == 1) ? 1 : (1 << c)) * ((x != 0) ? 4 : DIV);
  endfunction

  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask

  task test_done;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task rs(input reg pw);
    begin
      por_in <= pw;
      rst_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      por_in <= 1'b0;
    end
  endtask

  // Response ready is raised one edge late, in the same cycle the response turns valid, so no hold occurs
  task wr(input [7:0] a, input [7:0] dv, input [1:0] er);
    reg ap, wp;
    begin
      @(posedge clk_in);
      awaddr <= a;
      wdata <= {24'h0, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      while (ap || wp) begin
        @(posedge clk_in);
        if (awready) ap = 1'b0;
        if (wready) wp = 1'b0;
        awvalid <= ap;
        wvalid <= wp;
      end
      @(posedge clk_in);
      bready <= 1'b1;
      do @(posedge clk_in); while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er), "bresp");
    end
  endtask

  task rd(input [7:0] a, input [7:0] e, input [1:0] er);
    begin
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_in); while (!arready);
      arvalid <= 1'b0;
      @(posedge clk_in);
      rready <= 1'b1;
      do @(posedge clk_in); while (!rvalid);
      rready <= 1'b0;
      chk(32'(rresp), 32'(er), "rresp");
      if (er == 2'h0) chk(rdata, {24'h0, e}, "rdata");
    end
  endtask

  task per(input integer c, input integer x);
    begin
      wr(8'h10, 8'(c + 8 * x), 2'h0);
      repeat (2) begin
        do @(posedge clk_in); while (tick !== 1'b1);
      end
      n = 0;
      do begin
        @(posedge clk_in);
        n = n + 1;
      end while (tick !== 1'b1);
      chk(n, per_len(c, x), "period");
    end
  endtask

  initial begin
    #450000;
    num_errors = num_errors + 1;
    test_done;
  end

  initial begin
    rs(1'b1);
    rd(8'h04, 8'h1C, 2'h0);
    rd(8'h08, 8'h00, 2'h0);
    rd(8'h0C, 8'h3F, 2'h0);
    rd(8'h14, 8'h00, 2'h2);
    wr(8'h20, 8'hFF, 2'h2);
    v = 8'hD2;
    // Write once, then a plain reset keeps the reset pin choice
    for (i = 0; i < 2; i = i + 1) begin
      rd(8'h00, v, 2'h0);
      d = 8'($random(seed));
      d[5] = i[0];
      wr(8'h00, d, 2'h0);
      wr(8'h00, ~d, 2'h0);
      rd(8'h00, d & 8'hF3, 2'h0);
      chk(32'(wd_en), 32'(d[7]), "watchdog_enable");
      chk(32'(wd_long), 32'(d[6]), "watchdog_long");
      chk(32'(dbg), 32'(d[1]), "debug_pin");
      chk(32'(rpe), 32'(d[0]), "reset_pin");
      chk(32'(rpu), 32'(d[0]), "reset_pullup");
      @(posedge clk_in);
      stop_ex <= 1'b1;
      #1;
      chk(32'(st_en), 32'(d[5]), "stop_enter");
      chk(32'(st_ill), 32'(!d[5]), "stop_reset");
      @(posedge clk_in);
      stop_ex <= 1'b0;
      v = 8'hD2 | (d & 8'h01);
      rs(1'b0);
    end
    for (i = 0; i < 8; i = i + 1) begin
      p = (i == 0) ? 8'hFF : 8'($random(seed));
      s = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(8'h08, p, 2'h0);
      wr(8'h0C, s, 2'h0);
      rd(8'h08, p & 8'h3F, 2'h0);
      rd(8'h0C, s & 8'h3F, 2'h0);
      pin_o <= (i == 0) ? 6'h00 : 6'($random(seed));
      pin_a <= (i < 2) ? 6'h00 : 6'($random(seed));
      #1;
      chk(32'(pu), 32'(p[5:0] & ~pin_o & ~pin_a & 6'h2F), "pullup");
      chk(32'(sl), 32'(s[5:0] & pin_o & 6'h1F), "slew");
    end
    @(posedge clk_in);
    lv_ev <= 1'b1;
    @(posedge clk_in);
    lv_ev <= 1'b0;
    rd(8'h04, 8'h9C, 2'h0);
    wr(8'h04, 8'h5C, 2'h0);
    rd(8'h04, 8'h1C, 2'h0);
    chk(32'(bg), 32'h0, "bandgap");
    wr(8'h04, 8'h28, 2'h0);
    rd(8'h04, 8'h2C, 2'h0);
    chk(32'(low_voltage_detect_enable), 32'h1, "detect_enable");
    wr(8'h04, 8'h29, 2'h0);
    rd(8'h04, 8'h2D, 2'h0);
    chk(32'(bg), 32'h1, "bandgap");
    for (i = 1; i < 8; i = i + 1) per(i, 0);
    per(1, 1);
    per(2, 1);
    wr(8'h10, 8'h00, 2'h0);
    n = 0;
    repeat (400) begin
      @(posedge clk_in);
      if (tick === 1'b1) n = n + 1;
    end
    chk(n, 0, "ticks");
    test_done;
  end
endmodule
`default_nettype wire
